// ===== cpwm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cpwm_chk
   import cpwm_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        capture_pwm_output_pin,
   input wire logic        servo_update
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_err_unmapped: assert property (pready && (paddr > ADDR_STATUS || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("unmapped access not refused");
   a_clear_forces_low: assert property (pready && pwrite && paddr == ADDR_CONTROL
      && pwdata[3:0] != MODE_PWM |-> ##[1:2] !capture_pwm_output_pin)
      else $error("pin not low after clear");
   a_servo_pulse: assert property (servo_update |=> !servo_update)
      else $error("update event too long");
   a_rise_gap: assert property ($rose(capture_pwm_output_pin) |=> !$rose(capture_pwm_output_pin) [*3])
      else $error("period shorter than one increment");
   c_pin_rise: cover property ($rose(capture_pwm_output_pin));
   c_servo: cover property (servo_update);
   c_refused: cover property (pready && pslverr);
endmodule : cpwm_chk
bind cpwm_top cpwm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .capture_pwm_output_pin(capture_pwm_output_pin), .servo_update(servo_update));
`default_nettype wire

// ===== cpwm_load.sv
`timescale 1ns/1ps
`default_nettype none
module cpwm_load (
   input  wire logic pclk,
   input  wire logic pin,
   output int        high_len,
   output int        per_len
);
   int   hi_q   = 0;
   int   cnt_q  = 0;
   logic last_q = 1'b0;
   logic p;
   assign p = (pin === 1'b1); // pin taken as driven output, direction cleared
   initial high_len = 0;
   initial per_len = 0;
   always @(posedge pclk) begin
      last_q <= p;
      cnt_q  <= (p && !last_q) ? 1 : cnt_q + 1;
      hi_q   <= (p && !last_q) ? 1 : hi_q + int'(p);
      if (p && !last_q) per_len <= cnt_q;
      if (!p && last_q) high_len <= hi_q;
   end
endmodule : cpwm_load
`default_nettype wire

// ===== cpwm_pkg.sv
package cpwm_pkg;
   // register byte addresses
   localparam logic [7:0]  ADDR_CONTROL     = 8'h00;
   localparam logic [7:0]  ADDR_DUTY_BUFFER = 8'h04;
   localparam logic [7:0]  ADDR_DUTY_ACTIVE = 8'h08;
   localparam logic [7:0]  ADDR_PERIOD_CMP  = 8'h0C;
   localparam logic [7:0]  ADDR_TIMER_CTRL  = 8'h10;
   localparam logic [7:0]  ADDR_STATUS      = 8'h14;
   // control field positions
   localparam int          CTL_DUTY_LSB_POS = 4;
   localparam int          CTL_MODE_POS     = 0;
   localparam logic [3:0]  MODE_PWM         = 4'hC;
   // timer control fields
   localparam int          TCTL_ON_POS      = 2;
   localparam int          TCTL_PRE_POS     = 0;
   localparam int          TCTL_POST_POS    = 3;
   // reset values
   localparam logic [7:0]  RST_CONTROL      = 8'h00;
   localparam logic [7:0]  RST_DUTY_BUFFER  = 8'h00;
   localparam logic [7:0]  RST_PERIOD_CMP   = 8'hFF;
   localparam logic [7:0]  RST_TIMER_CTRL   = 8'h00;
   // one increment cycle is four oscillator periods
   localparam int          PHASE_COUNT      = 4;
   typedef enum logic [2:0] {
      CPWM_IDLE_S = 3'b001,
      CPWM_HIGH_S = 3'b010,
      CPWM_LOW_S  = 3'b100
   } cpwm_state_type;
endpackage : cpwm_pkg

// ===== cpwm_postscaler.sv
`timescale 1ns/1ps
`default_nettype none
module cpwm_postscaler
   import cpwm_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       period_evt,
   input  wire logic [3:0] post_sel,
   output logic            update_evt
);
   logic [3:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q      <= 4'h0;
         update_evt <= 1'b0;
      end else if (period_evt && cnt_q >= post_sel) begin
         cnt_q      <= 4'h0;
         update_evt <= 1'b1;
      end else begin
         update_evt <= 1'b0;
         if (period_evt) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule : cpwm_postscaler
`default_nettype wire

// ===== cpwm_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module cpwm_prescaler
   import cpwm_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic [1:0] prescale_sel,
   output logic            tick
);
   logic [3:0] cnt_q;
   logic [3:0] limit;

   always_comb begin
      case (prescale_sel)
         2'b00:   limit = 4'h0;
         2'b01:   limit = 4'h3;
         default: limit = 4'hF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_q <= 4'h0;
         tick  <= 1'b0;
      end else if (cnt_q >= limit) begin
         cnt_q <= 4'h0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         tick  <= 1'b0;
      end
   end
endmodule : cpwm_prescaler
`default_nettype wire

// ===== cpwm_top.sv
// Summary of operation
// - duty is 10 bits: buffer byte high, control bits 5:4 low
// - timer clears on increment after it equals period compare
// - output goes high at each rollover unless duty is zero
// - rollover copies buffered duty into active latch
// - duty writes accepted anytime, take effect at next period
// - active duty latch is read-only in pwm mode
// - output high for duty times oscillator period times prescale
// - clearing control forces output latch low
// - postscaler only gives a slower update event, not the period
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cpwm_top
   import cpwm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             capture_pwm_output_pin,
   output logic             servo_update
);
   import cpwm_pkg::*;

   logic [7:0]     capture_pwm_control_q;
   logic [7:0]     duty_buffer_byte_q;
   logic [9:0]     duty_active_latch_q;
   logic [7:0]     period_compare_q;
   logic [7:0]     timer_ctrl_q;
   logic [7:0]     period_timer_q;
   logic [1:0]     phase_q;
   logic           pwm_out_q;
   cpwm_state_type state_q;
   logic           presc_tick;
   logic           post_evt;
   logic           rollover;
   logic           pwm_mode;
   logic           wr_en;
   logic           rd_en;
   logic           timer_on;
   logic [9:0]     duty_buffered;
   logic [9:0]     fine_timer;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
      addr_hit = (a == r);
   endfunction : addr_hit

   assign wr_en         = psel && penable && pwrite;
   assign rd_en         = psel && !penable && !pwrite;
   assign pwm_mode      = capture_pwm_control_q[CTL_MODE_POS +: 4] == MODE_PWM;
   assign timer_on      = timer_ctrl_q[TCTL_ON_POS];
   assign duty_buffered = {duty_buffer_byte_q,
                           capture_pwm_control_q[CTL_DUTY_LSB_POS +: 2]};
   assign fine_timer    = {period_timer_q, phase_q};
   assign rollover      = presc_tick && (phase_q == 2'(PHASE_COUNT - 1))
                          && (period_timer_q == period_compare_q);

   cpwm_prescaler u_presc (
      .pclk         (pclk),
      .presetn      (presetn),
      .run          (timer_on),
      .prescale_sel (timer_ctrl_q[TCTL_PRE_POS +: 2]),
      .tick         (presc_tick)
   );

   cpwm_postscaler u_post (
      .pclk       (pclk),
      .presetn    (presetn),
      .period_evt (rollover),
      .post_sel   (timer_ctrl_q[TCTL_POST_POS +: 4]),
      .update_evt (post_evt)
   );

   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_pwm_control_q <= RST_CONTROL;
         duty_buffer_byte_q    <= RST_DUTY_BUFFER;
         period_compare_q      <= RST_PERIOD_CMP;
         timer_ctrl_q          <= RST_TIMER_CTRL;
      end else if (wr_en) begin
         if (addr_hit(paddr, ADDR_CONTROL)) begin
            capture_pwm_control_q <= pwdata[7:0];
         end
         if (addr_hit(paddr, ADDR_DUTY_BUFFER)) begin
            duty_buffer_byte_q <= pwdata[7:0];
         end
         if (addr_hit(paddr, ADDR_PERIOD_CMP)) begin
            period_compare_q <= pwdata[7:0];
         end
         if (addr_hit(paddr, ADDR_TIMER_CTRL)) begin
            timer_ctrl_q <= pwdata[7:0];
         end
      end
   end

   // active duty latch, loaded at rollover or by a write outside pwm mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_active_latch_q <= 10'h000;
      end else if (rollover) begin
         duty_active_latch_q <= duty_buffered;
      end else if (wr_en && !pwm_mode && addr_hit(paddr, ADDR_DUTY_ACTIVE)) begin
         duty_active_latch_q <= {pwdata[7:0], 2'b00};
      end
   end

   // period timer with phase bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_timer_q <= 8'h00;
         phase_q        <= 2'b00;
      end else if (presc_tick) begin
         phase_q <= phase_q + 2'b01;
         if (phase_q == 2'(PHASE_COUNT - 1)) begin
            if (period_timer_q == period_compare_q) begin
               period_timer_q <= 8'h00;
            end else begin
               period_timer_q <= period_timer_q + 8'h01;
            end
         end
      end
   end

   // output state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= CPWM_IDLE_S;
         pwm_out_q <= 1'b0;
      end else if (!pwm_mode) begin
         state_q   <= CPWM_IDLE_S;
         pwm_out_q <= 1'b0;
      end else begin
         case (state_q)
            CPWM_IDLE_S, CPWM_HIGH_S, CPWM_LOW_S: begin
               if (rollover) begin
                  if (duty_buffered != 10'h000) begin
                     state_q   <= CPWM_HIGH_S;
                     pwm_out_q <= 1'b1;
                  end else begin
                     state_q   <= CPWM_LOW_S;
                     pwm_out_q <= 1'b0;
                  end
               end else if (state_q == CPWM_HIGH_S && presc_tick
                            && fine_timer + 10'h001 == duty_active_latch_q) begin
                  state_q   <= CPWM_LOW_S;
                  pwm_out_q <= 1'b0;
               end
            end
            default: begin
               state_q   <= CPWM_IDLE_S;
               pwm_out_q <= 1'b0;
            end
         endcase
      end
   end

   // outputs and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_pwm_output_pin <= 1'b0;
         servo_update           <= 1'b0;
         prdata                 <= 32'h0000_0000;
      end else begin
         capture_pwm_output_pin <= pwm_out_q;
         servo_update           <= post_evt;
         if (rd_en) begin
            case (paddr)
               ADDR_CONTROL:     prdata <= {24'h00_0000, capture_pwm_control_q};
               ADDR_DUTY_BUFFER: prdata <= {24'h00_0000, duty_buffer_byte_q};
               ADDR_DUTY_ACTIVE: prdata <= {22'h00_0000, duty_active_latch_q};
               ADDR_PERIOD_CMP:  prdata <= {24'h00_0000, period_compare_q};
               ADDR_TIMER_CTRL:  prdata <= {24'h00_0000, timer_ctrl_q};
               ADDR_STATUS:      prdata <= {13'h0000, state_q, period_timer_q, phase_q, 5'h00, pwm_out_q};
               default:          prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(addr_hit(paddr, ADDR_CONTROL)
                    || addr_hit(paddr, ADDR_DUTY_BUFFER) || addr_hit(paddr, ADDR_DUTY_ACTIVE)
                    || addr_hit(paddr, ADDR_PERIOD_CMP) || addr_hit(paddr, ADDR_TIMER_CTRL)
                    || addr_hit(paddr, ADDR_STATUS));
      end
   end
endmodule : cpwm_top
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cpwm_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, pin, servo_update, er;
   int          fail_count = 0, checks_done = 0, seed = 32'hFEE0, high_len, per_len;
   int          pr, pre, post, duty, per, n, sv;
   cpwm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_pwm_output_pin(pin), .servo_update(servo_update));
   cpwm_load u_load (.pclk(pclk), .pin(pin), .high_len(high_len), .per_len(per_len));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic cmp_len(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_len
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 8);
      if (k >= 8) begin fail_count++; tally_and_finish(); end
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic count_win(input int cyc, output int hi, output int ev);
      hi = 0; ev = 0;
      repeat (cyc) begin
         @(posedge pclk);
         hi += int'(pin === 1'b1);
         ev += int'(servo_update === 1'b1);
      end
   endtask : count_win
   initial forever #25 pclk = ~pclk;
   initial begin
      repeat (100000) @(posedge pclk);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(ADDR_PERIOD_CMP, 1'b0, 32'h0); cmp_val(rd, {24'h0, RST_PERIOD_CMP});
      apb(8'h20, 1'b1, 32'h5A); cmp_val({31'h0, er}, 32'h1);
      apb(8'h20, 1'b0, 32'h0); cmp_val(rd, 32'h0);
      for (int i = 0; i < 6; i++) begin
         pr = 2 + i + ($random(seed) & 1);
         pre = ($random(seed) & 1) ? 4 : 1;
         post = $random(seed) & 3;
         per = (pr + 1) * 4 * pre;
         duty = (i == 0) ? 1 : (i == 1) ? (pr + 1) * 4 - 1 : 1 + (($random(seed) & 255) % ((pr + 1) * 4 - 1));
         apb(ADDR_TIMER_CTRL, 1'b1, 32'(post << TCTL_POST_POS | 1 << TCTL_ON_POS | int'(pre == 4)));
         apb(ADDR_PERIOD_CMP, 1'b1, 32'(pr));
         apb(ADDR_DUTY_BUFFER, 1'b1, 32'(duty >> 2));
         apb(ADDR_CONTROL, 1'b1, 32'((duty & 3) << CTL_DUTY_LSB_POS | MODE_PWM));
         repeat (3 * per + 4) @(posedge pclk);
         cmp_len(per_len, per);
         cmp_len(high_len, duty * pre);
         apb(ADDR_DUTY_ACTIVE, 1'b1, 32'h3FF);
         apb(ADDR_DUTY_ACTIVE, 1'b0, 32'h0); cmp_val(rd, 32'(duty));
         count_win(2 * (post + 1) * per, n, sv); cmp_len(sv, 2);
      end
      apb(ADDR_DUTY_BUFFER, 1'b1, 32'h0);
      apb(ADDR_CONTROL, 1'b1, 32'(MODE_PWM));
      repeat (2 * per + 2) @(posedge pclk);
      count_win(per, n, sv); cmp_len(n, 0);
      apb(ADDR_DUTY_BUFFER, 1'b1, 32'h1);
      repeat (2 * per + 2) @(posedge pclk);
      count_win(per, n, sv); cmp_len(n, 4 * pre);
      apb(ADDR_CONTROL, 1'b1, 32'h0);
      repeat (2) @(posedge pclk);
      count_win(per, n, sv); cmp_len(n, 0);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
